// ---- sbs_core.sv ----
// Purpose: Executes the set-all-ones and sleep instructions over four phases.
// Assumes: Each system clock is one phase; instructions arrive at phase one.
// Notes: The watchdog keeps counting during sleep so it can wake the core.
`include "sbs_regs.svh"
module sbs_core (
	input wire logic i_clk_sys,
	input wire logic i_reset_n,
	input wire logic i_instr_valid,
	input wire sbs_pkg::sbs_instr_t i_instr,
	input wire sbs_pkg::sbs_bank_t i_bank_select_reg,
	input wire logic i_ext_set_en,
	input wire sbs_pkg::sbs_addr_t i_index_base,
	input wire logic i_wdt_en,
	input wire logic i_wake_req,
	output logic [1:0] o_phase,
	output logic o_sleep,
	output logic o_osc_run,
	output logic o_power_down_flag,
	output logic o_timeout_flag,
	output sbs_pkg::sbs_wdt_pre_t o_watchdog_counter,
	output sbs_pkg::sbs_wdt_post_t o_watchdog_post,
	output logic o_wdt_reset,
	output logic o_wr_strobe,
	output sbs_pkg::sbs_addr_t o_wr_addr,
	output sbs_pkg::sbs_byte_t o_wr_data,
	output sbs_pkg::sbs_byte_t o_prev_byte
);
	import sbs_pkg::*;

	// ------------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------------
	sbs_phase_t phase_r, phase_nxt;
	sbs_state_e state_r, state_nxt;
	sbs_op_e op_r, op_nxt;
	sbs_addr_t addr_r, addr_nxt;
	sbs_byte_t prev_r, prev_nxt;
	logic pd_r, pd_nxt;
	logic to_r, to_nxt;
	sbs_wdt_pre_t pre_r, pre_nxt;
	sbs_wdt_post_t post_r, post_nxt;
	logic wdt_rst_r, wdt_rst_nxt;
	logic sleep_r, sleep_nxt;
	logic osc_r, osc_nxt;
	logic wr_stb_r, wr_stb_nxt;
	sbs_addr_t wr_addr_r, wr_addr_nxt;
	sbs_byte_t wr_data_r, wr_data_nxt;

	sbs_mem_if mem_bus ();

	sbs_mem sbs_mem_inst (
		.i_clk_sys(i_clk_sys),
		.bus(mem_bus)
	);

	// ------------------------------------------------------------------------
	// Decode helpers
	// ------------------------------------------------------------------------
	logic running;
	logic is_set_all_ones_op;
	logic is_sleep;
	logic wdt_clear;
	logic wdt_timeout;
	sbs_byte_t f_field;
	sbs_addr_t dec_addr;

	assign running = (state_r == SBS_ST_RUN);
	assign f_field = i_instr[`SBS_F_HI:`SBS_F_LO];
	assign is_set_all_ones_op = (i_instr[`SBS_OPC_HI:`SBS_OPC_LO] == `SBS_SET_ALL_ONES_OP_OPC);
	assign is_sleep = (i_instr == `SBS_SLEEP_OPC);
	// Clearing the watchdog in phase three leaves it clean before sleep begins.
	assign wdt_clear = running && (phase_r == `SBS_Q3) && (op_r == SBS_OP_SLEEP);
	// The clear suppresses a coincident time-out so the fresh flags survive.
	assign wdt_timeout = i_wdt_en && !wdt_clear && (pre_r == `SBS_WDT_PRE_MAX)
		&& (post_r == `SBS_WDT_POST_MAX);

	always_comb begin
		if (!i_instr[`SBS_A_BIT] && i_ext_set_en && (f_field <= `SBS_ILO_MAX)) begin
			dec_addr = sbs_addr_t'(i_index_base + sbs_addr_t'(f_field));
		end else if (!i_instr[`SBS_A_BIT]) begin
			if (f_field < `SBS_ACC_SPLIT) begin
				dec_addr = {`SBS_ACC_LO_BANK, f_field};
			end else begin
				dec_addr = {`SBS_ACC_HI_BANK, f_field};
			end
		end else begin
			dec_addr = {i_bank_select_reg, f_field};
		end
	end

	// ------------------------------------------------------------------------
	// Memory access
	// ------------------------------------------------------------------------
	assign mem_bus.addr = addr_r;
	assign mem_bus.wdata = `SBS_ONES;
	assign mem_bus.re = running && (phase_r == `SBS_Q2) && (op_r == SBS_OP_SET_ALL_ONES_OP);
	assign mem_bus.we = running && (phase_r == `SBS_Q4) && (op_r == SBS_OP_SET_ALL_ONES_OP);

	// ------------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------------
	always_comb begin
		phase_nxt = phase_r;
		state_nxt = state_r;
		op_nxt = op_r;
		addr_nxt = addr_r;
		prev_nxt = prev_r;
		pd_nxt = pd_r;
		to_nxt = to_r;
		pre_nxt = pre_r;
		post_nxt = post_r;
		wdt_rst_nxt = 1'b0;
		sleep_nxt = sleep_r;
		osc_nxt = osc_r;
		wr_stb_nxt = 1'b0;
		wr_addr_nxt = wr_addr_r;
		wr_data_nxt = wr_data_r;

		if (wdt_clear) begin
			pre_nxt = `SBS_WDT_PRE_CLR;
			post_nxt = `SBS_WDT_POST_CLR;
		end else if (i_wdt_en) begin
			pre_nxt = sbs_wdt_pre_t'(pre_r + 1'b1);
			if (pre_r == `SBS_WDT_PRE_MAX) begin
				post_nxt = sbs_wdt_post_t'(post_r + 1'b1);
			end
		end

		case (state_r)
			SBS_ST_RUN: begin
				phase_nxt = sbs_phase_t'(phase_r + 1'b1);
				case (phase_r)
					`SBS_Q1: begin
						op_nxt = SBS_OP_NONE;
						if (i_instr_valid && is_set_all_ones_op) begin
							op_nxt = SBS_OP_SET_ALL_ONES_OP;
							addr_nxt = dec_addr;
						end else if (i_instr_valid && is_sleep) begin
							op_nxt = SBS_OP_SLEEP;
						end
					end
					`SBS_Q3: begin
						if (op_r == SBS_OP_SET_ALL_ONES_OP) begin
							prev_nxt = mem_bus.rdata;
						end else if (op_r == SBS_OP_SLEEP) begin
							pd_nxt = 1'b0;
							to_nxt = 1'b1;
						end
					end
					`SBS_Q4: begin
						if (op_r == SBS_OP_SET_ALL_ONES_OP) begin
							wr_stb_nxt = 1'b1;
							wr_addr_nxt = addr_r;
							wr_data_nxt = `SBS_ONES;
						end else if (op_r == SBS_OP_SLEEP) begin
							state_nxt = SBS_ST_SLEEP;
							sleep_nxt = 1'b1;
							osc_nxt = 1'b0;
							phase_nxt = `SBS_Q1;
						end
						op_nxt = SBS_OP_NONE;
					end
					default: begin
					end
				endcase
			end
			SBS_ST_SLEEP: begin
				phase_nxt = `SBS_Q1;
				if (wdt_timeout || i_wake_req) begin
					state_nxt = SBS_ST_RUN;
					sleep_nxt = 1'b0;
					osc_nxt = 1'b1;
				end
			end
			default: begin
				state_nxt = SBS_ST_RUN;
			end
		endcase

		if (wdt_timeout) begin
			to_nxt = 1'b0;
			wdt_rst_nxt = running;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_reset_n) begin
			phase_r <= `SBS_Q1;
			state_r <= SBS_ST_RUN;
			op_r <= SBS_OP_NONE;
			addr_r <= '0;
			prev_r <= '0;
			pd_r <= `SBS_PD_RST;
			to_r <= `SBS_TO_RST;
			pre_r <= `SBS_WDT_PRE_CLR;
			post_r <= `SBS_WDT_POST_CLR;
			wdt_rst_r <= 1'b0;
			sleep_r <= 1'b0;
			osc_r <= 1'b1;
			wr_stb_r <= 1'b0;
			wr_addr_r <= '0;
			wr_data_r <= '0;
		end else begin
			phase_r <= phase_nxt;
			state_r <= state_nxt;
			op_r <= op_nxt;
			addr_r <= addr_nxt;
			prev_r <= prev_nxt;
			pd_r <= pd_nxt;
			to_r <= to_nxt;
			pre_r <= pre_nxt;
			post_r <= post_nxt;
			wdt_rst_r <= wdt_rst_nxt;
			sleep_r <= sleep_nxt;
			osc_r <= osc_nxt;
			wr_stb_r <= wr_stb_nxt;
			wr_addr_r <= wr_addr_nxt;
			wr_data_r <= wr_data_nxt;
		end
	end

	assign o_phase = phase_r;
	assign o_sleep = sleep_r;
	assign o_osc_run = osc_r;
	assign o_power_down_flag = pd_r;
	assign o_timeout_flag = to_r;
	assign o_watchdog_counter = pre_r;
	assign o_watchdog_post = post_r;
	assign o_wdt_reset = wdt_rst_r;
	assign o_wr_strobe = wr_stb_r;
	assign o_wr_addr = wr_addr_r;
	assign o_wr_data = wr_data_r;
	assign o_prev_byte = prev_r;

	// ------------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------------
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_reset_n);

	sequence s_set_all_ones_op_dec;
		running && phase_r == `SBS_Q1 && i_instr_valid && is_set_all_ones_op;
	endsequence
	sequence s_sleep_dec;
		running && phase_r == `SBS_Q1 && i_instr_valid && is_sleep;
	endsequence

	chk_set_all_ones_op_ones: assert property (o_wr_strobe |-> o_wr_data == `SBS_ONES)
		else $error("set-all-ones wrote a value other than all ones");
	chk_bank_select: assert property ((s_set_all_ones_op_dec and i_instr[`SBS_A_BIT])
		|=> addr_r == {$past(i_bank_select_reg), $past(f_field)})
		else $error("banked address not taken from bank select");
	chk_access_bank: assert property ((s_set_all_ones_op_dec and (!i_instr[`SBS_A_BIT]
		&& (!i_ext_set_en || f_field > `SBS_ILO_MAX)))
		|=> addr_r[`SBS_F_HI:`SBS_F_LO] == $past(f_field)
		&& addr_r[11:8] == ($past(f_field) < `SBS_ACC_SPLIT ? `SBS_ACC_LO_BANK
		: `SBS_ACC_HI_BANK))
		else $error("access bank address wrong");
	chk_indexed_mode: assert property ((s_set_all_ones_op_dec and (!i_instr[`SBS_A_BIT] && i_ext_set_en
		&& f_field <= `SBS_ILO_MAX))
		|=> addr_r == sbs_addr_t'($past(i_index_base) + sbs_addr_t'($past(f_field))))
		else $error("indexed offset address wrong");
	chk_sleep_entry: assert property (s_sleep_dec |-> ##4 (o_sleep && !o_osc_run))
		else $error("sleep not entered four phases after decode");
	chk_pd_cleared: assert property (s_sleep_dec |-> ##3 !o_power_down_flag)
		else $error("power-down flag not cleared by sleep");
	chk_to_set: assert property (s_sleep_dec |-> ##3 o_timeout_flag)
		else $error("time-out flag not set by sleep");
	chk_wdt_cleared: assert property (s_sleep_dec |-> ##3 (o_watchdog_counter
		== `SBS_WDT_PRE_CLR && o_watchdog_post == `SBS_WDT_POST_CLR) ##1 o_sleep)
		else $error("watchdog not cleared before sleep");
	chk_wdt_wake: assert property (o_sleep && wdt_timeout
		|=> !o_timeout_flag && !o_sleep && o_osc_run)
		else $error("watchdog wake did not clear time-out flag");
	chk_wdt_pulse: assert property (running && wdt_timeout
		|=> o_wdt_reset && !o_timeout_flag)
		else $error("running watchdog expiry gave no reset pulse");
	chk_set_all_ones_op_cycle: assert property (s_set_all_ones_op_dec |-> ##1 mem_bus.re ##2 mem_bus.we
		##1 (o_wr_strobe && o_wr_addr == $past(addr_r)))
		else $error("set-all-ones phases out of order");
endmodule

// ---- sbs_core_tb.sv ----
// Purpose: Self-checking bench for the set-all-ones and sleep execution core.
// Assumes: One phase per clock; inputs change by non-blocking assignment on the rising edge.
// Notes: Data memory is not reset, so the old byte is only judged after a known write.
`include "sbs_regs.svh"
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin \
	$display("ERROR %s expected %h seen %h", nm, ex, got); n_mismatch++; end end
module sbs_core_tb_top;
	import sbs_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0, rst_n = 1'b0, valid = 1'b0, ext = 1'b0, wdt_en = 1'b0, wake = 1'b0;
	sbs_instr_t instr = 16'h0000;
	sbs_bank_t bank_select_reg = 4'h0;
	sbs_addr_t base = 12'h000;
	logic [1:0] phase;
	logic slp, osc, pd, tmo, wdt_rst, strobe;
	sbs_wdt_pre_t wcnt;
	sbs_wdt_post_t wpost;
	sbs_addr_t waddr;
	sbs_byte_t wdata, prev;
	int n_mismatch = 0;
	int compares = 0;

	always #50 clk = ~clk;

	sbs_core sbs_core_inst (.i_clk_sys(clk), .i_reset_n(rst_n), .i_instr_valid(valid),
		.i_instr(instr), .i_bank_select_reg(bank_select_reg), .i_ext_set_en(ext), .i_index_base(base),
		.i_wdt_en(wdt_en), .i_wake_req(wake), .o_phase(phase), .o_sleep(slp),
		.o_osc_run(osc), .o_power_down_flag(pd), .o_timeout_flag(tmo),
		.o_watchdog_counter(wcnt), .o_watchdog_post(wpost), .o_wdt_reset(wdt_rst),
		.o_wr_strobe(strobe), .o_wr_addr(waddr), .o_wr_data(wdata), .o_prev_byte(prev));

	// ------------------------------------------------------------------------
	// Shared drivers
	// ------------------------------------------------------------------------
	task automatic finish_test();
		if (n_mismatch == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Returns right after the edge that takes the word.
	task automatic do_op(input sbs_instr_t w);
		@(negedge clk);
		while (phase !== 2'h3) @(negedge clk);
		@(posedge clk);
		valid <= 1'b1;
		instr <= w;
		@(posedge clk);
		valid <= 1'b0;
	endtask

	task automatic set_all_ones_op_chk(input logic a, input sbs_byte_t f, input sbs_bank_t b,
		input logic e, input sbs_addr_t ba, input sbs_addr_t exp_addr, input logic old_ff);
		@(posedge clk);
		bank_select_reg <= b;
		ext <= e;
		base <= ba;
		do_op({7'h34, a, f});
		repeat (2) @(posedge clk);
		#1;
		`CHK("strobe early", 1'b0, strobe)
		@(posedge clk);
		#1;
		`CHK("strobe", 1'b1, strobe)
		`CHK("wr_addr", exp_addr, waddr)
		`CHK("wr_data", 8'hFF, wdata)
		if (old_ff) `CHK("prev_byte", 8'hFF, prev)
		@(posedge clk);
		#1;
		`CHK("strobe end", 1'b0, strobe)
	endtask

	// ------------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------------
	task automatic t_banks();
		set_all_ones_op_chk(1'b1, 8'h20, 4'h3, 1'b0, 12'h000, 12'h320, 1'b0);
		set_all_ones_op_chk(1'b1, 8'h20, 4'h3, 1'b0, 12'h000, 12'h320, 1'b1);
		set_all_ones_op_chk(1'b0, 8'h10, 4'h3, 1'b0, 12'h000, 12'h010, 1'b0);
		set_all_ones_op_chk(1'b0, 8'h90, 4'h3, 1'b0, 12'h000, 12'hF90, 1'b0);
		set_all_ones_op_chk(1'b1, 8'h10, 4'h7, 1'b1, 12'h500, 12'h710, 1'b0);
	endtask

	task automatic t_indexed();
		set_all_ones_op_chk(1'b0, 8'h5F, 4'h2, 1'b1, 12'h100, 12'h15F, 1'b0);
		set_all_ones_op_chk(1'b0, 8'h00, 4'h2, 1'b1, 12'hFF8, 12'hFF8, 1'b0);
		set_all_ones_op_chk(1'b0, 8'h60, 4'h2, 1'b1, 12'h100, 12'h060, 1'b0);
		set_all_ones_op_chk(1'b0, 8'hF0, 4'h2, 1'b1, 12'h100, 12'hFF0, 1'b0);
	endtask

	task automatic t_nop();
		do_op(16'h0002);
		repeat (5) begin
			@(posedge clk);
			#1;
			`CHK("nop strobe", 1'b0, strobe)
			`CHK("nop sleep", 1'b0, slp)
		end
	endtask

	task automatic t_sleep(input logic by_wdt);
		int n;
		n = 0;
		@(posedge clk);
		wdt_en <= 1'b1;
		repeat (40) @(posedge clk);
		do_op(`SBS_SLEEP_OPC);
		repeat (2) @(posedge clk);
		#1;
		`CHK("power_down", 1'b0, pd)
		`CHK("timeout", 1'b1, tmo)
		`CHK("wdt count", 8'h00, wcnt)
		`CHK("wdt post", 4'h0, wpost)
		@(posedge clk);
		#1;
		`CHK("sleep", 1'b1, slp)
		`CHK("osc", 1'b0, osc)
		if (!by_wdt) begin
			@(posedge clk);
			wdt_en <= 1'b0;
			wake <= 1'b1;
			@(posedge clk);
			wake <= 1'b0;
			#1;
			`CHK("timeout kept", 1'b1, tmo)
			`CHK("wake phase", 2'h0, phase)
			`CHK("wdt reset", 1'b0, wdt_rst)
		end else begin
			// The watchdog restarted from zero, so expiry is some 4096 cycles away.
			while (slp === 1'b1 && n < 5000) begin
				@(negedge clk);
				n++;
			end
			`CHK("timeout wdt", 1'b0, tmo)
			`CHK("wdt wake phase", 2'h0, phase)
			`CHK("wdt reset asleep", 1'b0, wdt_rst)
			`CHK("power_down kept", 1'b0, pd)
			@(posedge clk);
			wdt_en <= 1'b0;
		end
		#1;
		`CHK("woken", 1'b0, slp)
		`CHK("osc back", 1'b1, osc)
	endtask

	// ------------------------------------------------------------------------
	// Main sequence and watchdog
	// ------------------------------------------------------------------------
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		`CHK("rst power_down", 1'b1, pd)
		`CHK("rst timeout", 1'b1, tmo)
		`CHK("rst osc", 1'b1, osc)
		t_banks();
		t_indexed();
		t_nop();
		t_sleep(1'b0);
		t_sleep(1'b1);
		set_all_ones_op_chk(1'b1, 8'h20, 4'h3, 1'b0, 12'h000, 12'h320, 1'b1);
		finish_test();
	end

	initial begin
		#(20000 * 100);
		n_mismatch++;
		finish_test();
	end
endmodule

// ---- sbs_mem.sv ----
// Purpose: Data memory holding the general purpose bytes.
// Assumes: Single port, registered read data.
// Notes: Contents are not reset; software must initialise them.
`include "sbs_regs.svh"
module sbs_mem (
	input wire logic i_clk_sys,
	sbs_mem_if.mem bus
);
	import sbs_pkg::*;
	sbs_byte_t mem_r [`SBS_MEM_DEPTH];
	sbs_byte_t rdata_r;

	always_ff @(posedge i_clk_sys) begin
		if (bus.we) begin
			mem_r[bus.addr] <= bus.wdata;
		end
		if (bus.re) begin
			rdata_r <= mem_r[bus.addr];
		end
	end

	assign bus.rdata = rdata_r;
endmodule

// ---- sbs_mem_if.sv ----
// Purpose: Carrier between the execution core and the data memory.
// Assumes: Read data appear one clock after a read enable.
// Notes: Ctrl drives address and strobes, mem answers.
interface sbs_mem_if;
	import sbs_pkg::*;
	sbs_addr_t addr;
	sbs_byte_t wdata;
	sbs_byte_t rdata;
	logic re;
	logic we;
	modport ctrl (output addr, output wdata, output re, output we, input rdata);
	modport mem (input addr, input wdata, input re, input we, output rdata);
endinterface

// ---- sbs_pkg.sv ----
// Purpose: Shared types of the set-all-ones and sleep execution block.
// Assumes: Twelve-bit data addresses and sixteen-bit instruction words.
// Notes: Numeric constants live in sbs_regs.svh.
package sbs_pkg;
	typedef logic [1:0] sbs_phase_t;
	typedef logic [15:0] sbs_instr_t;
	typedef logic [11:0] sbs_addr_t;
	typedef logic [7:0] sbs_byte_t;
	typedef logic [3:0] sbs_bank_t;
	typedef logic [7:0] sbs_wdt_pre_t;
	typedef logic [3:0] sbs_wdt_post_t;
	typedef enum logic {SBS_ST_RUN, SBS_ST_SLEEP} sbs_state_e;
	typedef enum logic [1:0] {SBS_OP_NONE, SBS_OP_SET_ALL_ONES_OP, SBS_OP_SLEEP} sbs_op_e;
endpackage

// ---- sbs_regs.svh ----
// Purpose: Constants for the set-all-ones and sleep execution block.
// Assumes: One instruction cycle is four system clocks, one per phase.
// Notes: Included by the core and memory files.
`ifndef SBS_REGS_SVH
`define SBS_REGS_SVH

// ----------------------------------------------------------------------------
// Instruction cycle phases
// ----------------------------------------------------------------------------
`define SBS_Q1 2'h0
`define SBS_Q2 2'h1
`define SBS_Q3 2'h2
`define SBS_Q4 2'h3

// ----------------------------------------------------------------------------
// Opcode fields
// ----------------------------------------------------------------------------
`define SBS_OPC_HI 15
`define SBS_OPC_LO 9
`define SBS_A_BIT 8
`define SBS_F_HI 7
`define SBS_F_LO 0
`define SBS_SET_ALL_ONES_OP_OPC 7'h34
`define SBS_SLEEP_OPC 16'h0003

// ----------------------------------------------------------------------------
// Data and addressing
// ----------------------------------------------------------------------------
`define SBS_ONES 8'hFF
`define SBS_ILO_MAX 8'h5F
`define SBS_ACC_SPLIT 8'h80
`define SBS_ACC_LO_BANK 4'h0
`define SBS_ACC_HI_BANK 4'hF
`define SBS_MEM_DEPTH 4096

// ----------------------------------------------------------------------------
// Watchdog and status reset values
// ----------------------------------------------------------------------------
`define SBS_WDT_PRE_MAX 8'hFF
`define SBS_WDT_POST_MAX 4'hF
`define SBS_WDT_PRE_CLR 8'h00
`define SBS_WDT_POST_CLR 4'h0
`define SBS_PD_RST 1'b1
`define SBS_TO_RST 1'b1

`endif
